// file: piv_pkg.sv
package piv_pkg;
  localparam int unsigned NUM_LEVELS = 16;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned NUM_EXT = 8;
  // Vector base and stride for native mode
  localparam logic [15:0] VEC_BASE = 16'h0400;
  localparam int unsigned VEC_STRIDE_SHIFT = 2;
  // Emulated-mode pointer table
  localparam logic [15:0] LINK_BASE = 16'h0020;
  localparam int unsigned LINK_STRIDE_SHIFT = 1;
  // Level numbers with special handling
  localparam int unsigned LVL_POWER_DOWN = 0;
  localparam int unsigned LVL_MACH_ERR = 1;
  localparam int unsigned LVL_EXEC_CALL = 5;
  // Levels that are not edge-triggered: 3, 5, 6
  localparam logic [15:0] LEVEL_SENSE = 16'h0068;
  // Levels that ignore mask: 0, 5
  localparam logic [15:0] NO_MASK = 16'h0021;
  // Levels that ignore global disable: 0, 1, 5
  localparam logic [15:0] NO_DISABLE = 16'h0023;
  // Levels cleared by master reset: 0, 5
  localparam logic [15:0] RST_CLEAR = 16'h0021;
  // Level positions of external inputs: user a..f, io a..b
  localparam logic [3:0] EXT_USER_A = 4'h2;
  localparam logic [3:0] EXT_USER_B = 4'h8;
  localparam logic [3:0] EXT_USER_C = 4'hA;
  localparam logic [3:0] EXT_USER_D = 4'hB;
  localparam logic [3:0] EXT_USER_E = 4'hD;
  localparam logic [3:0] EXT_USER_F = 4'hF;
  localparam logic [3:0] EXT_IO_A = 4'hC;
  localparam logic [3:0] EXT_IO_B = 4'hE;
  localparam logic [15:0] PEND_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] SAVE_RESET = 16'h0000;

  typedef struct packed {
    logic valid;
    logic [3:0] level;
    logic [15:0] native_vec;
    logic [15:0] link_ptr;
    logic [15:0] svc_ptr;
  } piv_vector_t;

  typedef struct packed {
    logic take;
    logic call;
    logic [15:0] counter;
  } piv_seq_t;
endpackage

// file: piv_arbiter.sv
`timescale 1ns/100ps
module piv_arbiter (
  input wire logic [piv_pkg::NUM_LEVELS-1:0] eligible,
  output piv_pkg::piv_vector_t vec
);
  import piv_pkg::*;

  // Lowest index wins: level 0 highest priority
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  wire logic [4:0] sel = first_set(eligible);
  wire logic [15:0] lvl16 = {12'h000, sel[3:0]};

  assign vec.valid = ~sel[4];
  assign vec.level = sel[3:0];
  assign vec.native_vec = VEC_BASE + (lvl16 << VEC_STRIDE_SHIFT);
  assign vec.link_ptr = LINK_BASE + (lvl16 << LINK_STRIDE_SHIFT);
  assign vec.svc_ptr = LINK_BASE + (lvl16 << LINK_STRIDE_SHIFT) + 16'h0001;
endmodule

// file: piv_core.sv
`timescale 1ns/100ps
module piv_core (
  input wire logic clk,
  input wire logic srst,
  input wire logic master_reset_n,
  input wire logic native_mode,
  input wire logic [5:0] ext_user_irq,
  input wire logic [1:0] io_level_irq,
  input wire logic [piv_pkg::NUM_LEVELS-1:0] internal_irq,
  input wire logic irq_ack,
  input wire logic call_op,
  input wire logic [15:0] instruction_counter,
  input wire logic global_enable_set,
  input wire logic mask_we,
  input wire logic [15:0] mask_wdata,
  output logic [15:0] pending_interrupts,
  output logic [15:0] interrupt_mask,
  output logic [15:0] counter_save_reg,
  output logic global_enable,
  output logic irq_req,
  output piv_pkg::piv_vector_t vector,
  output logic counter_load,
  output logic [15:0] counter_load_value
);
  import piv_pkg::*;

  // External pins are asynchronous to clk
  logic [7:0] ext_s1;
  logic [7:0] ext_s2;
  logic master_reset_n_s1;
  logic master_reset_n_s2;
  logic [15:0] src_prev;

  wire logic [7:0] ext_raw = {io_level_irq, ext_user_irq};

  function automatic logic [15:0] map_ext(input logic [7:0] e);
    logic [15:0] m;
    m = 16'h0000;
    m[EXT_USER_A] = e[0];
    m[EXT_USER_B] = e[1];
    m[EXT_USER_C] = e[2];
    m[EXT_USER_D] = e[3];
    m[EXT_USER_E] = e[4];
    m[EXT_USER_F] = e[5];
    m[EXT_IO_A] = e[6];
    m[EXT_IO_B] = e[7];
    return m;
  endfunction

  localparam logic [15:0] EXT_LEVELS = 16'hFD04;

  // Internal sources own every level not claimed by a pin in native mode
  wire logic [15:0] ext_map = map_ext(ext_s2);
  wire logic [15:0] src_now = native_mode ? ((ext_map & EXT_LEVELS) | (internal_irq & ~EXT_LEVELS))
    : internal_irq;
  wire logic [15:0] rise = src_now & ~src_prev;
  wire logic [15:0] set_bits = (rise & ~LEVEL_SENSE) | (src_now & LEVEL_SENSE);

  wire logic [15:0] mask_ok = interrupt_mask | NO_MASK;
  wire logic [15:0] enable_ok = global_enable ? 16'hFFFF : NO_DISABLE;
  wire logic [15:0] eligible = pending_interrupts & mask_ok & enable_ok;

  piv_vector_t arb_vec;

  piv_arbiter u_arb (
    .eligible(eligible),
    .vec(arb_vec)
  );

  assign vector = arb_vec;
  assign irq_req = arb_vec.valid;

  wire logic take = irq_ack & arb_vec.valid;
  wire logic native_take = take && native_mode;
  wire logic [15:0] taken_bit = take ? (16'h0001 << arb_vec.level) : 16'h0000;
  wire logic master_reset_n_active = ~master_reset_n_s2;
  wire logic [15:0] rst_clr = master_reset_n_active ? RST_CLEAR : 16'h0000;
  wire logic [15:0] set_kept = set_bits & ~rst_clr;

  // A new set wins over the service clear; master reset beats both on 0 and 5
  wire logic [15:0] next_pending = ((pending_interrupts & ~taken_bit) | set_bits) & ~rst_clr;

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_s1 <= 8'h00;
      ext_s2 <= 8'h00;
      master_reset_n_s1 <= 1'b1;
      master_reset_n_s2 <= 1'b1;
      src_prev <= 16'h0000;
    end else begin
      ext_s1 <= ext_raw;
      ext_s2 <= ext_s1;
      master_reset_n_s1 <= master_reset_n;
      master_reset_n_s2 <= master_reset_n_s1;
      src_prev <= src_now;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pending_interrupts <= PEND_RESET;
    end else begin
      pending_interrupts <= next_pending;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      interrupt_mask <= MASK_RESET;
    end else if (mask_we) begin
      interrupt_mask <= mask_wdata;
    end
  end

  // Interrupt entry takes precedence over a call in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      counter_save_reg <= SAVE_RESET;
    end else if (take && native_mode) begin
      counter_save_reg <= instruction_counter;
    end else if (call_op) begin
      counter_save_reg <= instruction_counter;
    end
  end

  // Disable stays set until the core re-enables; service code must read the save first
  always_ff @(posedge clk) begin
    if (srst) begin
      global_enable <= 1'b0;
    end else if (take && native_mode) begin
      global_enable <= 1'b0;
    end else if (global_enable_set) begin
      global_enable <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      counter_load <= 1'b0;
      counter_load_value <= 16'h0000;
    end else begin
      counter_load <= take && native_mode;
      if (take) begin
        counter_load_value <= native_mode ? arb_vec.native_vec : arb_vec.link_ptr;
      end
    end
  end

  property p_save_on_take;
    @(posedge clk) disable iff (srst)
      (take && native_mode) |=> (counter_save_reg == $past(instruction_counter)) && !global_enable;
  endproperty
  a_save_on_take: assert property (p_save_on_take) else $error("save or disable missing on take");

  property p_vector_value;
    @(posedge clk) disable iff (srst)
      (take && native_mode) |=> counter_load && counter_load_value == (16'h0400 + {10'h000, $past(arb_vec.level), 2'b00});
  endproperty
  a_vector_value: assert property (p_vector_value) else $error("wrong native vector");

  property p_mask_blocks;
    @(posedge clk) disable iff (srst)
      arb_vec.valid |-> (interrupt_mask[arb_vec.level] || arb_vec.level == 4'd0 || arb_vec.level == 4'd5);
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked level selected");

  property p_disable_blocks;
    @(posedge clk) disable iff (srst)
      (arb_vec.valid && !global_enable) |-> (arb_vec.level <= 4'd1 || arb_vec.level == 4'd5);
  endproperty
  a_disable_blocks: assert property (p_disable_blocks) else $error("disabled level selected");

  property p_nmi_taken;
    @(posedge clk) disable iff (srst)
      pending_interrupts[0] |-> (arb_vec.valid && arb_vec.level == 4'd0);
  endproperty
  a_nmi_taken: assert property (p_nmi_taken) else $error("level 0 not selected");

  property p_priority;
    @(posedge clk) disable iff (srst)
      arb_vec.valid |-> ((eligible & ((16'h0001 << arb_vec.level) - 16'h0001)) == 16'h0000);
  endproperty
  a_priority: assert property (p_priority) else $error("higher level skipped");

  property p_clear_one;
    @(posedge clk) disable iff (srst)
      (take && set_bits == 16'h0000 && !master_reset_n_active) |=> pending_interrupts == ($past(pending_interrupts) & ~$past(taken_bit));
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("pending clear wrong");

  property p_master_reset;
    @(posedge clk) disable iff (srst)
      master_reset_n_active |=> (pending_interrupts[0] == 1'b0 && pending_interrupts[5] == 1'b0);
  endproperty
  a_master_reset: assert property (p_master_reset) else $error("levels 0/5 not cleared");

  property p_call_save;
    @(posedge clk) disable iff (srst)
      (call_op && !(take && native_mode)) |=> counter_save_reg == $past(instruction_counter);
  endproperty
  a_call_save: assert property (p_call_save) else $error("call did not save counter");

  property p_edge_set;
    @(posedge clk) disable iff (srst)
      (rise[2] && !master_reset_n_active) |=> pending_interrupts[2];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge not latched");

  property p_ext_ignored;
    @(posedge clk) disable iff (srst)
      (native_mode && !pending_interrupts[8] && !ext_map[8]) |=> !pending_interrupts[8];
  endproperty
  a_ext_ignored: assert property (p_ext_ignored) else $error("core source set a pin level");

  property p_emul_internal;
    @(posedge clk) disable iff (srst)
      (!native_mode && internal_irq[8] && !src_prev[8]) |=> pending_interrupts[8];
  endproperty
  a_emul_internal: assert property (p_emul_internal) else $error("emulated source not latched");

  property p_level_sense;
    @(posedge clk) disable iff (srst)
      src_now[3] |=> pending_interrupts[3];
  endproperty
  a_level_sense: assert property (p_level_sense) else $error("held level not latched");

  property p_edge_only;
    @(posedge clk) disable iff (srst)
      (src_prev[4] && !pending_interrupts[4]) |=> !pending_interrupts[4];
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("held edge source set again");

  property p_pending_set;
    @(posedge clk) disable iff (srst)
      (set_kept != 16'h0000) |=> ((pending_interrupts & $past(set_kept)) == $past(set_kept));
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("pending bit not set");

  property p_load_pulse;
    @(posedge clk) disable iff (srst)
      counter_load |-> $past(native_take);
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load without native take");

  property p_emul_no_save;
    @(posedge clk) disable iff (srst)
      (take && !native_mode && !call_op) |=> $stable(counter_save_reg) && !counter_load;
  endproperty
  a_emul_no_save: assert property (p_emul_no_save) else $error("emulated take saved counter");

  property p_emul_vector;
    @(posedge clk) disable iff (srst)
      (take && !native_mode) |=> counter_load_value == (16'h0020 + {11'h000, $past(arb_vec.level), 1'b0});
  endproperty
  a_emul_vector: assert property (p_emul_vector) else $error("wrong linkage pointer");

  property p_svc_ptr;
    @(posedge clk) disable iff (srst)
      arb_vec.valid |-> (arb_vec.svc_ptr == arb_vec.link_ptr + 16'h0001);
  endproperty
  a_svc_ptr: assert property (p_svc_ptr) else $error("service pointer not next");

  property p_mask_write;
    @(posedge clk) disable iff (srst)
      mask_we |=> interrupt_mask == $past(mask_wdata);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_level5_free;
    @(posedge clk) disable iff (srst)
      pending_interrupts[5] |-> (arb_vec.valid && arb_vec.level <= 4'd5);
  endproperty
  a_level5_free: assert property (p_level5_free) else $error("level 5 blocked");

  property p_level1_mask;
    @(posedge clk) disable iff (srst)
      (pending_interrupts[1] && interrupt_mask[1]) |-> (arb_vec.valid && arb_vec.level <= 4'd1);
  endproperty
  a_level1_mask: assert property (p_level1_mask) else $error("level 1 blocked by disable");

  property p_idle_req;
    @(posedge clk) disable iff (srst)
      (eligible == 16'h0000) |-> !irq_req;
  endproperty
  a_idle_req: assert property (p_idle_req) else $error("request with nothing eligible");

  property p_enable_set;
    @(posedge clk) disable iff (srst)
      (global_enable_set && !native_take) |=> global_enable;
  endproperty
  a_enable_set: assert property (p_enable_set) else $error("re-enable lost");
endmodule

// file: piv_seq_model.sv
`timescale 1ns/100ps
// Sequencer stand-in: takes an offered vector after a selectable number of idle cycles
module piv_seq_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic [1:0] slow,
  input wire logic offer,
  output logic irq_ack
);
  logic [1:0] wait_cnt;
  initial begin
    irq_ack = 1'b0;
    wait_cnt = 2'h0;
  end
  // Ack is a single-cycle pulse, so one offer is taken once
  always @(posedge clk) begin
    if (srst || !enable || !offer || irq_ack) begin
      irq_ack <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (wait_cnt == slow) begin
      irq_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
  import piv_pkg::*;
  logic clk = 0, srst = 1, master_reset_n = 1, native_mode = 1, auto_ack = 0;
  logic call_op = 0, ge_set = 0, mask_we = 0, ge, irq_req, irq_ack, ld;
  logic [1:0] slow = 0, io_irq = 0;
  logic [5:0] usr_irq = 0;
  logic [15:0] int_irq = 0, ic = 16'h1234, mask_wdata = 0, pend, mask, save, ld_val;
  piv_vector_t vec;
  int failures = 0, checks_done = 0;
  always #25 clk = ~clk;
  piv_core u_piv_core (.clk(clk), .srst(srst), .master_reset_n(master_reset_n), .native_mode(native_mode),
    .ext_user_irq(usr_irq), .io_level_irq(io_irq), .internal_irq(int_irq), .irq_ack(irq_ack),
    .call_op(call_op), .instruction_counter(ic), .global_enable_set(ge_set), .mask_we(mask_we),
    .mask_wdata(mask_wdata), .pending_interrupts(pend), .interrupt_mask(mask), .counter_save_reg(save),
    .global_enable(ge), .irq_req(irq_req), .vector(vec), .counter_load(ld), .counter_load_value(ld_val));
  piv_seq_model u_piv_seq_model (.clk(clk), .srst(srst), .enable(auto_ack), .slow(slow),
    .offer(vec.valid), .irq_ack(irq_ack));
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Pulse the source of one level for a single cycle
  task automatic raise(input int lv);
    case (lv)
      2: usr_irq[0] = 1;
      8: usr_irq[1] = 1;
      10: usr_irq[2] = 1;
      11: usr_irq[3] = 1;
      13: usr_irq[4] = 1;
      15: usr_irq[5] = 1;
      12: io_irq[0] = 1;
      14: io_irq[1] = 1;
      default: int_irq[lv] = 1;
    endcase
    cyc(1);
    usr_irq = 0;
    io_irq = 0;
    int_irq = 0;
  endtask
  task automatic write_mask(input logic [15:0] m);
    mask_wdata = m;
    mask_we = 1;
    cyc(1);
    mask_we = 0;
  endtask
  task automatic enable_irqs;
    ge_set = 1;
    cyc(1);
    ge_set = 0;
  endtask
  task automatic take;
    slow = 0;
    auto_ack = 1;
    cyc(2);
    auto_ack = 0;
    cyc(1);
  endtask
  task automatic t_vectors;
    int n;
    write_mask(16'hFFFF);
    chk("mask", mask, 16'hFFFF);
    for (int lv = 0; lv < 16; lv++) begin
      enable_irqs;
      ic = 16'h5000 + lv[15:0];
      slow = lv[1:0];
      auto_ack = 1;
      raise(lv);
      n = 0;
      while (irq_req !== 1'b1 && n < 8) begin
        cyc(1);
        n++;
      end
      chk("level", {12'h000, vec.level}, lv[15:0]);
      chk("native_vec", vec.native_vec, 16'h0400 + 16'(lv * 4));
      chk("link_ptr", vec.link_ptr, 16'h0020 + 16'(lv * 2));
      chk("svc_ptr", vec.svc_ptr, 16'h0021 + 16'(lv * 2));
      cyc(2 + int'(slow));
      chk("load", {15'h0000, ld}, 16'h0001);
      chk("load_value", ld_val, 16'h0400 + 16'(lv * 4));
      chk("save", save, ic);
      chk("enable", {15'h0000, ge}, 16'h0000);
      chk("pending", pend, 16'h0000);
    end
    auto_ack = 0;
    $display("t_vectors done");
  endtask
  task automatic t_mask;
    write_mask(16'h0000);
    raise(4);
    raise(1);
    cyc(1);
    chk("pending", pend, 16'h0012);
    chk("masked req", {15'h0000, irq_req}, 16'h0000);
    raise(5);
    cyc(1);
    chk("unmaskable", {12'h000, vec.level}, 16'h0005);
    take;
    chk("one cleared", pend, 16'h0012);
    write_mask(16'h0012);
    chk("machine error", {12'h000, vec.level}, 16'h0001);
    take;
    chk("disabled req", {15'h0000, irq_req}, 16'h0000);
    enable_irqs;
    chk("late enable", {12'h000, vec.level}, 16'h0004);
    take;
    $display("t_mask done");
  endtask
  task automatic t_misc;
    raise(0);
    cyc(3);
    chk("power down", {12'h000, vec.level}, 16'h0000);
    master_reset_n = 0;
    cyc(4);
    chk("reset clear", pend, 16'h0000);
    master_reset_n = 1;
    write_mask(16'h0018);
    int_irq = 16'h0018;
    cyc(2);
    enable_irqs;
    take;
    chk("level held", pend, 16'h0018);
    int_irq = 16'h0010;
    enable_irqs;
    take;
    enable_irqs;
    take;
    chk("edge held", pend, 16'h0000);
    int_irq = 0;
    ic = 16'hBEEF;
    call_op = 1;
    cyc(1);
    call_op = 0;
    chk("call save", save, 16'hBEEF);
    $display("t_misc done");
  endtask
  task automatic t_emul;
    write_mask(16'hFFFF);
    int_irq = 16'h0100;
    cyc(1);
    int_irq = 0;
    cyc(1);
    chk("pin level from core", pend, 16'h0000);
    native_mode = 0;
    ic = 16'h7777;
    int_irq = 16'h0100;
    cyc(1);
    int_irq = 0;
    chk("emulated set", pend, 16'h0100);
    enable_irqs;
    chk("emulated level", {12'h000, vec.level}, 16'h0008);
    chk("emulated link", vec.link_ptr, 16'h0030);
    chk("emulated svc", vec.svc_ptr, 16'h0031);
    take;
    chk("emulated load", ld_val, 16'h0030);
    chk("emulated save", save, 16'hBEEF);
    chk("emulated enable", {15'h0000, ge}, 16'h0001);
    chk("emulated pending", pend, 16'h0000);
    native_mode = 1;
    $display("t_emul done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #(50 * 2000);
    failures++;
    final_report;
  end
  initial begin
    cyc(6);
    srst = 0;
    cyc(1);
    chk("mask reset", mask, MASK_RESET);
    t_vectors;
    t_mask;
    t_misc;
    t_emul;
    final_report;
  end
endmodule
